// ### hdl/radio_framer_map.svh
// Offsets, reset values and timing figures of the packet framer.
// Assumes inclusion by its bare name from the design.
`ifndef RADIO_FRAMER_MAP_SVH
`define RADIO_FRAMER_MAP_SVH
// Register addresses, six bits each
`define ADR_CTRL 6'h00
`define ADR_MODE 6'h01
`define ADR_TXLEN 6'h02
`define ADR_SEEDLO 6'h03
`define ADR_SEEDHI 6'h04
`define ADR_MISSCNT 6'h05
`define ADR_STATUS 6'h06
`define ADR_RXLEN 6'h07
`define ADR_TXFIFO 6'h20
`define ADR_RXFIFO 6'h21
// Control field positions
`define CTRL_TXGO 0
`define CTRL_RXGO 1
`define CTRL_SEQ 2
`define CTRL_CRC 3
`define CTRL_MARK 4
`define CTRL_LEN 5
`define CTRL_MISS 6
`define CTRL_ZSEED 7
// Reset values
`define CTRL_RST 8'h38
`define MISS_RST 8'h04
// Byte times in ns at each raw rate
`define BYTE_NS_FSK 8000
`define BYTE_NS_8L32 32000
`define BYTE_NS_8L64 64000
`define BYTE_NS_DR32 128000
`define BYTE_NS_DR64 256000
`define BYTE_NS_SR64 511836
`define CLK_NS 4
// Checksum polynomial, without the x^16 term
`define CRC_POLY 16'h8005
`define FIFO_DEPTH 16
`endif

// ### hdl/radio_framer_pkg.sv
// Types shared by the packet framer.
// Assumes nothing beside it; uses no map header macros.
package radio_framer_pkg;
	// Data-rate modes
	typedef enum logic [2:0] {
		M_FSK = 3'h0, M_8L32 = 3'h1, M_8L64 = 3'h2,
		M_DR32 = 3'h3, M_DR64 = 3'h4, M_SR64 = 3'h5
	} mode_t;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		S_IDLE = 6'h01, S_WARM = 6'h02, S_TX = 6'h04,
		S_ACKWAIT = 6'h08, S_RX = 6'h10, S_ACKTX = 6'h20
	} seq_t;
	// Configuration written over the serial port
	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] mode;
		logic [7:0] txLen;
		logic [15:0] seed;
		logic [7:0] missLimit;
	} cfg_t;
	// Sticky status bits
	typedef struct packed {
		logic rxOverflow;
		logic ackTimeout;
		logic ackGot;
		logic crcErr;
		logic rxDone;
		logic txDone;
	} stat_t;
endpackage

// ### hdl/radio_packet_framer.sv
// Serial slave port, packet framer, buffers and acknowledge sequencer.
// Assumes the modem exchanges whole bytes on clk; serial pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "radio_framer_map.svh"
////////////////////////////////////////////////////////////////////////
// What this block does
// - Command byte: bit7 write, increment, address
// - Increment flag advances address per data byte
// - Burst lasts until select rises
// - Serial clock in, 4-pin or 3-pin
// - Two-symbol start marker, per-mode on receive; transmit always sends it
// - Unframed: two correlations infer packet start
// - Marker code separate, equal length both ends
// - Optional length byte after marker
// - End after length plus checksum bytes
// - Alternative end after non-correlation count
// - Sixteen-bit checksum appended and checked
// - Seed or zero seed; either accepted
// - Sixteen-byte transmit and receive buffers
// - Buffer level flags allow FIFO use
// - Sequenced send: warm up, send, await ack
// - Return idle on ack or timeout
// - Sequenced receive: good packet, send ack
// - Acknowledges leave buffers untouched
// - Receiver takes any rate unconfigured
// - Byte timing per raw data rate
// - Three-pin line driven only while reading
// - Buffer addresses never increment
// - Port works while radio sleeps
module radio_packet_framer #(
	parameter int BYTE_NS_FSK = `BYTE_NS_FSK,
	parameter int BYTE_NS_8L32 = `BYTE_NS_8L32,
	parameter int BYTE_NS_8L64 = `BYTE_NS_8L64,
	parameter int BYTE_NS_DR32 = `BYTE_NS_DR32,
	parameter int BYTE_NS_DR64 = `BYTE_NS_DR64,
	parameter int BYTE_NS_SR64 = `BYTE_NS_SR64,
	parameter int WARM_CYCLES = 64,
	parameter int ACK_TIMEOUT_CYCLES = 100000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ssN, // Slave select, low active
	input wire logic sck,
	input wire logic mosi,
	input wire logic threePin, // Shared data line wiring
	input wire logic bidirSerialLineIn,
	output logic bidirSerialLineOut,
	output logic bidirSerialLineOe,
	output logic misoOut,
	output logic misoOe,
	input wire logic [7:0] rxData, // Modem byte in
	input wire logic rxValid,
	input wire logic rxMarker, // Start marker found
	input wire logic corrHit,
	input wire logic corrMiss,
	output logic [7:0] txData,
	output logic txStrobe,
	output logic txMarker,
	output logic [2:0] modemMode,
	output logic synthOn,
	output logic radioTx,
	output logic radioRx,
	output logic txFifoLow,
	output logic rxFifoHigh,
	output logic packetDone
);
	localparam logic [17:0] WARM_N = 18'(WARM_CYCLES);
	localparam logic [17:0] ACK_N = 18'(ACK_TIMEOUT_CYCLES);
	////////////////////////////////////////////////////////////////////
	// Synchronisers for the serial pins
	logic [1:0] ssQ, sckQ, mosiQ, sdatQ;
	logic sckD;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ssQ <= 2'h3;
			sckQ <= 2'h0;
			mosiQ <= 2'h0;
			sdatQ <= 2'h0;
			sckD <= 1'b0;
		end else begin
			ssQ <= {ssQ[0], ssN};
			sckQ <= {sckQ[0], sck};
			mosiQ <= {mosiQ[0], mosi};
			sdatQ <= {sdatQ[0], bidirSerialLineIn};
			sckD <= sckQ[1];
		end
	end
	////////////////////////////////////////////////////////////////////
	// Shared state declarations
	radio_framer_pkg::cfg_t cfg, next_cfg;
	radio_framer_pkg::stat_t stat, next_stat;
	logic [7:0] txMem [0:`FIFO_DEPTH-1];
	logic [7:0] rxMem [0:`FIFO_DEPTH-1];
	logic [4:0] txWr, txRd, rxWr, rxRd, next_txWr, next_txRd, next_rxWr, next_rxRd;
	logic [7:0] rxLenSeen, next_rxLenSeen;
	radio_framer_pkg::seq_t seq, next_seq;
	// Buffer addresses stay put in a burst
	function automatic logic isFifo(input logic [5:0] a);
		isFifo = (a == `ADR_TXFIFO) || (a == `ADR_RXFIFO);
	endfunction
	// Register read view
	function automatic logic [7:0] readReg(input logic [5:0] a);
		case (a)
			`ADR_CTRL: readReg = cfg.ctrl;
			`ADR_MODE: readReg = {5'h00, cfg.mode};
			`ADR_TXLEN: readReg = cfg.txLen;
			`ADR_SEEDLO: readReg = cfg.seed[7:0];
			`ADR_SEEDHI: readReg = cfg.seed[15:8];
			`ADR_MISSCNT: readReg = cfg.missLimit;
			`ADR_STATUS: readReg = {2'h0, stat};
			`ADR_RXLEN: readReg = rxLenSeen;
			`ADR_RXFIFO: readReg = rxMem[rxRd[3:0]];
			default: readReg = 8'h00;
		endcase
	endfunction
	// Checksum over one byte, first bit sent first
	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
		end
		crcByte = r;
	endfunction
	////////////////////////////////////////////////////////////////////
	// Serial slave port, mode 0, bytes MSB first
	logic [2:0] bitCnt, next_bitCnt;
	logic firstByte, next_firstByte, isWrite, next_isWrite, incr, next_incr;
	logic [5:0] addr, next_addr;
	logic [7:0] shIn, next_shIn, shOut, next_shOut;
	logic next_misoOut, next_misoOe, next_sdatOe;
	logic wrStb, rdPop;
	logic [5:0] wrAddr;
	logic [7:0] wrData;
	always_comb begin
		logic din, rise, fall;
		logic [7:0] b;
		din = threePin ? sdatQ[1] : mosiQ[1];
		rise = sckQ[1] & ~sckD;
		fall = ~sckQ[1] & sckD;
		b = {shIn[6:0], din};
		next_bitCnt = bitCnt;
		next_firstByte = firstByte;
		next_isWrite = isWrite;
		next_incr = incr;
		next_addr = addr;
		next_shIn = shIn;
		next_shOut = shOut;
		next_misoOut = misoOut;
		wrStb = 1'b0;
		rdPop = 1'b0;
		wrAddr = addr;
		wrData = b;
		if (ssQ[1]) begin
			// Idle select: serial clock is ignored
			next_bitCnt = 3'h0;
			next_firstByte = 1'b1;
		end else if (rise) begin
			next_shIn = b;
			next_bitCnt = bitCnt + 3'h1;
			if (bitCnt == 3'h7) begin
				if (firstByte) begin
					next_firstByte = 1'b0;
					next_isWrite = b[7];
					next_incr = b[6];
					next_addr = b[5:0];
					next_shOut = readReg(b[5:0]);
					rdPop = !b[7] && (b[5:0] == `ADR_RXFIFO);
				end else begin
					// Advance only scalar registers when asked
					if (incr && !isFifo(addr)) begin
						next_addr = addr + 6'h01;
					end
					if (isWrite) begin
						wrStb = 1'b1;
					end else begin
						next_shOut = readReg(next_addr);
						rdPop = (next_addr == `ADR_RXFIFO);
					end
				end
			end
		end else if (fall && !firstByte && !isWrite) begin
			next_misoOut = shOut[7];
			next_shOut = {shOut[6:0], 1'b0};
		end
		// Drive the line only in the data phase of a read
		next_misoOe = !ssQ[1] && !firstByte && !isWrite && !threePin;
		next_sdatOe = !ssQ[1] && !firstByte && !isWrite && threePin;
	end
	// Serial port registers, clocked by clk so sleep does not matter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bitCnt <= 3'h0;
			firstByte <= 1'b1;
			isWrite <= 1'b0;
			incr <= 1'b0;
			addr <= 6'h00;
			shIn <= 8'h00;
			shOut <= 8'h00;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
			bidirSerialLineOe <= 1'b0;
		end else begin
			bitCnt <= next_bitCnt;
			firstByte <= next_firstByte;
			isWrite <= next_isWrite;
			incr <= next_incr;
			addr <= next_addr;
			shIn <= next_shIn;
			shOut <= next_shOut;
			misoOut <= next_misoOut;
			misoOe <= next_misoOe;
			bidirSerialLineOe <= next_sdatOe;
		end
	end
	assign bidirSerialLineOut = misoOut;
	////////////////////////////////////////////////////////////////////
	// Framer, buffers and sequencer
	logic [17:0] tick, next_tick;
	logic [2:0] txPh, next_txPh;
	logic [7:0] txCnt, next_txCnt, rxLen, next_rxLen, rxCnt, next_rxCnt, missCnt, next_missCnt;
	logic [15:0] txCrc, next_txCrc, crcA, next_crcA, crcZ, next_crcZ;
	logic [7:0] crcHi, next_crcHi;
	logic [1:0] rxPh, next_rxPh;
	logic rxAct, next_rxAct, hitPrev, next_hitPrev;
	logic [7:0] next_txData;
	logic next_txStrobe, next_txMarker, txPush, rxPush, next_packetDone;
	// Byte slot length per raw rate
	function automatic logic [17:0] period(input logic [2:0] m);
		case (m)
			radio_framer_pkg::M_FSK: period = 18'(BYTE_NS_FSK / `CLK_NS);
			radio_framer_pkg::M_8L32: period = 18'(BYTE_NS_8L32 / `CLK_NS);
			radio_framer_pkg::M_8L64: period = 18'(BYTE_NS_8L64 / `CLK_NS);
			radio_framer_pkg::M_DR32: period = 18'(BYTE_NS_DR32 / `CLK_NS);
			radio_framer_pkg::M_DR64: period = 18'(BYTE_NS_DR64 / `CLK_NS);
			default: period = 18'(BYTE_NS_SR64 / `CLK_NS);
		endcase
	endfunction
	always_comb begin
		logic markOn, lenOn, missOn, crcOn, acking, rxEnd, good, start;
		logic [15:0] rxGot;
		// Mode forces or forbids length, and the marker on receive only
		markOn = (cfg.mode <= 3'h2) || (cfg.mode != 3'h5 && cfg.ctrl[`CTRL_MARK]);
		lenOn = markOn && ((cfg.mode <= 3'h2) || cfg.ctrl[`CTRL_LEN]);
		missOn = (cfg.mode != 3'h0) && cfg.ctrl[`CTRL_MISS];
		crcOn = cfg.ctrl[`CTRL_CRC];
		acking = (seq == radio_framer_pkg::S_ACKTX);
		next_cfg = cfg;
		next_stat = stat;
		next_seq = seq;
		next_tick = tick;
		next_txPh = txPh;
		next_txCnt = txCnt;
		next_txCrc = txCrc;
		next_txData = txData;
		next_txStrobe = 1'b0;
		next_txMarker = 1'b0;
		next_packetDone = 1'b0;
		next_rxAct = rxAct;
		next_rxPh = rxPh;
		next_rxLen = rxLen;
		next_rxCnt = rxCnt;
		next_crcA = crcA;
		next_crcZ = crcZ;
		next_crcHi = crcHi;
		next_missCnt = missCnt;
		next_hitPrev = hitPrev;
		next_rxLenSeen = rxLenSeen;
		txPush = 1'b0;
		rxPush = 1'b0;
		rxEnd = 1'b0;
		good = 1'b0;
		rxGot = {crcHi, rxData};
		// Register writes from the serial port
		if (wrStb) begin
			case (wrAddr)
				`ADR_CTRL: next_cfg.ctrl = wrData;
				`ADR_MODE: next_cfg.mode = wrData[2:0];
				`ADR_TXLEN: next_cfg.txLen = wrData;
				`ADR_SEEDLO: next_cfg.seed[7:0] = wrData;
				`ADR_SEEDHI: next_cfg.seed[15:8] = wrData;
				`ADR_MISSCNT: next_cfg.missLimit = wrData;
				`ADR_STATUS: next_stat = stat & ~wrData[5:0];
				`ADR_TXFIFO: txPush = (txWr - txRd) != 5'(`FIFO_DEPTH);
				default: next_cfg = cfg;
			endcase
		end
		// Receiver: start on marker or on two correlations in a row
		start = markOn ? rxMarker : (corrHit && hitPrev);
		if (corrHit) begin
			next_hitPrev = 1'b1;
		end else if (corrMiss) begin
			next_hitPrev = 1'b0;
		end
		if (!(seq == radio_framer_pkg::S_RX || seq == radio_framer_pkg::S_ACKWAIT)) begin
			next_rxAct = 1'b0;
		end else if (!rxAct && start) begin
			// Any rate decodes; the modem handles spreading
			next_rxAct = 1'b1;
			next_rxPh = lenOn ? 2'h0 : 2'h1;
			next_rxLen = 8'hFF;
			next_rxCnt = 8'h00;
			next_crcA = cfg.seed;
			next_crcZ = 16'h0000;
			next_missCnt = 8'h00;
		end else if (rxAct) begin
			if (rxValid) begin
				case (rxPh)
					2'h0: begin
						next_rxLen = rxData;
						next_rxPh = (rxData != 8'h00) ? 2'h1 : (crcOn ? 2'h2 : 2'h1);
						rxEnd = (rxData == 8'h00) && !crcOn;
						good = rxEnd;
					end
					2'h1: begin
						next_crcA = crcByte(crcA, rxData);
						next_crcZ = crcByte(crcZ, rxData);
						next_rxCnt = rxCnt + 8'h01;
						// Acks in flight never touch the receive buffer
						if (seq != radio_framer_pkg::S_ACKWAIT) begin
							rxPush = (rxWr - rxRd) != 5'(`FIFO_DEPTH);
							next_stat.rxOverflow = !rxPush || next_stat.rxOverflow;
						end
						if (lenOn && next_rxCnt == rxLen) begin
							next_rxPh = crcOn ? 2'h2 : 2'h1;
							rxEnd = !crcOn;
							good = rxEnd;
						end
					end
					2'h2: begin
						next_crcHi = rxData;
						next_rxPh = 2'h3;
					end
					default: begin
						rxEnd = 1'b1;
						good = (rxGot == crcA) || (rxGot == crcZ);
						next_stat.crcErr = !good || next_stat.crcErr;
					end
				endcase
			end else if (corrMiss && missOn) begin
				next_missCnt = missCnt + 8'h01;
				rxEnd = (next_missCnt >= cfg.missLimit);
				good = rxEnd;
			end else if (corrHit) begin
				next_missCnt = 8'h00;
			end
		end
		if (rxEnd) begin
			next_rxAct = 1'b0;
			next_rxLenSeen = rxCnt + (rxPh == 2'h1 && rxValid ? 8'h01 : 8'h00);
		end
		// Transmit byte slots at the configured rate
		if (seq == radio_framer_pkg::S_TX || acking) begin
			next_tick = (tick == 18'h00000) ? period(cfg.mode) - 18'h00001 : tick - 18'h00001;
			if (tick == 18'h00000) begin
				case (txPh)
					3'h0: begin
						next_txMarker = 1'b1;
						next_txPh = lenOn ? 3'h1 : 3'h2;
						next_txCrc = cfg.ctrl[`CTRL_ZSEED] ? 16'h0000 : cfg.seed;
						next_txCnt = 8'h00;
					end
					3'h1: begin
						next_txData = acking ? 8'h00 : cfg.txLen;
						next_txStrobe = 1'b1;
						next_txPh = 3'h2;
					end
					3'h2: begin
						if (!acking && txCnt < cfg.txLen) begin
							// Stall the slot while the buffer is empty
							if (txWr != txRd) begin
								next_txData = txMem[txRd[3:0]];
								next_txStrobe = 1'b1;
								next_txCrc = crcByte(txCrc, txMem[txRd[3:0]]);
								next_txCnt = txCnt + 8'h01;
							end
						end else begin
							next_txPh = crcOn ? 3'h3 : 3'h5;
						end
					end
					3'h3: begin
						next_txData = txCrc[15:8];
						next_txStrobe = 1'b1;
						next_txPh = 3'h4;
					end
					3'h4: begin
						next_txData = txCrc[7:0];
						next_txStrobe = 1'b1;
						next_txPh = 3'h5;
					end
					default: next_txPh = 3'h5;
				endcase
			end
		end else begin
			next_tick = 18'h00000;
			next_txPh = 3'h0;
		end
		// Sequencer
		case (seq)
			radio_framer_pkg::S_IDLE: begin
				next_tick = WARM_N;
				if (cfg.ctrl[`CTRL_TXGO]) begin
					next_cfg.ctrl[`CTRL_TXGO] = 1'b0;
					next_seq = radio_framer_pkg::S_WARM;
				end else if (cfg.ctrl[`CTRL_RXGO]) begin
					next_cfg.ctrl[`CTRL_RXGO] = 1'b0;
					next_seq = radio_framer_pkg::S_RX;
				end
			end
			radio_framer_pkg::S_WARM: begin
				next_tick = (tick == 18'h00000) ? 18'h00000 : tick - 18'h00001;
				if (tick == 18'h00000) begin
					next_seq = radio_framer_pkg::S_TX;
				end
			end
			radio_framer_pkg::S_TX: begin
				if (txPh == 3'h5) begin
					next_stat.txDone = 1'b1;
					next_packetDone = 1'b1;
					next_tick = ACK_N;
					next_seq = cfg.ctrl[`CTRL_SEQ] ? radio_framer_pkg::S_ACKWAIT : radio_framer_pkg::S_IDLE;
				end
			end
			radio_framer_pkg::S_ACKWAIT: begin
				next_tick = tick - 18'h00001;
				if (rxEnd && good) begin
					next_stat.ackGot = 1'b1;
					next_seq = radio_framer_pkg::S_IDLE;
				end else if (tick == 18'h00000) begin
					next_stat.ackTimeout = 1'b1;
					next_seq = radio_framer_pkg::S_IDLE;
				end
			end
			radio_framer_pkg::S_RX: begin
				if (rxEnd) begin
					next_stat.rxDone = 1'b1;
					next_packetDone = 1'b1;
					if (!cfg.ctrl[`CTRL_SEQ]) begin
						next_seq = radio_framer_pkg::S_IDLE;
					end else if (good) begin
						next_seq = radio_framer_pkg::S_ACKTX;
					end
				end
			end
			radio_framer_pkg::S_ACKTX: begin
				if (txPh == 3'h5) begin
					next_seq = radio_framer_pkg::S_RX;
				end
			end
			default: next_seq = radio_framer_pkg::S_IDLE;
		endcase
		// Buffer pointers
		next_txWr = txWr + (txPush ? 5'h01 : 5'h00);
		next_txRd = txRd + (next_txStrobe && txPh == 3'h2 ? 5'h01 : 5'h00);
		next_rxWr = rxWr + (rxPush ? 5'h01 : 5'h00);
		next_rxRd = rxRd + (rdPop && rxWr != rxRd ? 5'h01 : 5'h00);
	end
	// Framer registers and buffer pointers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= '{ctrl: `CTRL_RST, mode: 3'h0, txLen: 8'h00, seed: 16'h0000, missLimit: `MISS_RST};
			stat <= '0;
			seq <= radio_framer_pkg::S_IDLE;
			{txWr, txRd, rxWr, rxRd} <= 20'h00000;
			{tick, txPh, txCnt, txCrc} <= 45'h0;
			{rxAct, rxPh, rxLen, rxCnt, missCnt, hitPrev} <= 28'h0;
			{crcA, crcZ, crcHi, rxLenSeen} <= 48'h0;
			{txData, txStrobe, txMarker, packetDone} <= 11'h000;
			{modemMode, synthOn, radioTx, radioRx, txFifoLow, rxFifoHigh} <= 8'h00;
		end else begin
			cfg <= next_cfg;
			stat <= next_stat;
			seq <= next_seq;
			{txWr, txRd, rxWr, rxRd} <= {next_txWr, next_txRd, next_rxWr, next_rxRd};
			{tick, txPh, txCnt, txCrc} <= {next_tick, next_txPh, next_txCnt, next_txCrc};
			{rxAct, rxPh, rxLen, rxCnt, missCnt, hitPrev} <=
				{next_rxAct, next_rxPh, next_rxLen, next_rxCnt, next_missCnt, next_hitPrev};
			{crcA, crcZ, crcHi, rxLenSeen} <= {next_crcA, next_crcZ, next_crcHi, next_rxLenSeen};
			{txData, txStrobe, txMarker, packetDone} <= {next_txData, next_txStrobe, next_txMarker, next_packetDone};
			modemMode <= cfg.mode;
			synthOn <= (next_seq != radio_framer_pkg::S_IDLE);
			radioTx <= (next_seq == radio_framer_pkg::S_TX) || (next_seq == radio_framer_pkg::S_ACKTX);
			radioRx <= (next_seq == radio_framer_pkg::S_RX) || (next_seq == radio_framer_pkg::S_ACKWAIT);
			txFifoLow <= (next_txWr - next_txRd) <= 5'h08;
			rxFifoHigh <= (next_rxWr - next_rxRd) >= 5'h08;
		end
	end
	// Buffer arrays hold no reset
	always_ff @(posedge clk) begin
		if (txPush) begin
			txMem[txWr[3:0]] <= wrData;
		end
		if (rxPush) begin
			rxMem[rxWr[3:0]] <= rxData;
		end
	end
endmodule
`default_nettype wire

// ### bench/spi_master_model.sv
// Serial master model: mode 0 transactions, most significant bit first.
// Assumes calls start just after a clock edge; the bench resolves the shared line.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	output logic ssN,
	output logic sck,
	output logic dOut,
	output logic dOe,
	input wire logic dIn
);
	// Deselected, clock stands still between frames
	initial begin
		ssN = 1'b1;
		sck = 1'b0;
		dOut = 1'b1;
		dOe = 1'b0;
	end
	// One byte; a released line toggles every bit
	task automatic shift(input logic [7:0] o, input logic drv, output logic [7:0] i);
		for (int b = 7; b >= 0; b--) begin
			dOut = drv ? o[b] : ~dOut;
			dOe = drv;
			#24 sck = 1'b1;
			i[b] = dIn;
			#24 sck = 1'b0;
		end
	endtask
	// Command byte then every byte of q, answers replace q
	task automatic xfer(input logic [7:0] cmd, ref logic [7:0] q[$]);
		logic [7:0] junk;
		ssN = 1'b0;
		#24 shift(cmd, 1'b1, junk);
		foreach (q[k]) shift(q[k], cmd[7], q[k]);
		dOe = 1'b0;
		#24 ssN = 1'b1;
		#48;
	endtask
endmodule
`default_nettype wire

// ### bench/framer_chk.sv
// Port-level checks of the packet framer.
// Assumes one clock domain; bound into radio_packet_framer below.
`timescale 1ns/1ps
`default_nettype none
module framer_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ssN,
	input wire logic threePin,
	input wire logic misoOe,
	input wire logic bidirSerialLineOe,
	input wire logic txStrobe,
	input wire logic txMarker,
	input wire logic synthOn,
	input wire logic radioTx,
	input wire logic radioRx,
	input wire logic packetDone
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	// Serial pins
	chk_one_driver: assert property (!(misoOe && bidirSerialLineOe))
		else $error("both read drivers on");
	chk_shared_only: assert property (bidirSerialLineOe |-> threePin)
		else $error("shared line driven in four-pin wiring");
	chk_miso_only: assert property (misoOe |-> !threePin)
		else $error("read pin driven in three-pin wiring");
	chk_quiet_deselect: assert property (ssN [*8] |-> !misoOe && !bidirSerialLineOe)
		else $error("read driver on while deselected");
	////////////////////////////////////////////////////////////////////////
	// Modem side
	chk_strobe_spacing: assert property (txStrobe |=> !txStrobe [*8])
		else $error("byte slots too close");
	chk_marker_slot: assert property (txMarker |=> !txStrobe [*8])
		else $error("byte follows marker too early");
	chk_radio_apart: assert property (!(radioTx && radioRx))
		else $error("send and receive together");
	chk_tx_synth: assert property (radioTx |-> synthOn)
		else $error("sending without synthesizer");
	chk_strobe_tx: assert property (txStrobe |-> radioTx)
		else $error("byte sent outside send state");
	chk_done_pulse: assert property (packetDone |=> !packetDone)
		else $error("packet end longer than one cycle");
endmodule
bind radio_packet_framer framer_chk chk_u (.clk(clk), .reset_n(reset_n), .ssN(ssN), .threePin(threePin),
	.misoOe(misoOe), .bidirSerialLineOe(bidirSerialLineOe), .txStrobe(txStrobe), .txMarker(txMarker),
	.synthOn(synthOn), .radioTx(radioTx), .radioRx(radioRx), .packetDone(packetDone));
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench: registers, send frames, receive frames, acknowledge sequencer.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, reset_n, ssN, sck, dOut, dOe, threePin, rxValid, rxMarker, corrHit = 1'b0, corrMiss = 1'b0;
	logic bidirSerialLineOut, bidirSerialLineOe, misoOut, misoOe, txStrobe, txMarker;
	logic synthOn, radioTx, radioRx, txFifoLow, rxFifoHigh, packetDone;
	logic [7:0] rxData, txData;
	logic [2:0] modemMode, mode;
	logic [15:0] seed;
	logic [31:0] rng = 32'h34545637;
	logic [7:0] q[$], txSeen[$], pay[$];
	logic [7:0] rv[6] = '{8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
	int failCount = 0;
	int nCompared = 0;
	int markCount = 0;
	int doneCount = 0;
	wire line, masterIn;
	// Shared line: device while reading, else the master's pattern
	assign line = bidirSerialLineOe ? bidirSerialLineOut : dOut;
	assign masterIn = threePin ? line : (misoOe ? misoOut : ~misoOut);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	spi_master_model m_u (.ssN(ssN), .sck(sck), .dOut(dOut), .dOe(dOe), .dIn(masterIn));
	radio_packet_framer #(.BYTE_NS_FSK(400), .WARM_CYCLES(8), .ACK_TIMEOUT_CYCLES(500)) dut_u (
		.clk(clk), .reset_n(reset_n), .ssN(ssN), .sck(sck), .mosi(dOut), .threePin(threePin),
		.bidirSerialLineIn(line), .bidirSerialLineOut(bidirSerialLineOut), .bidirSerialLineOe(bidirSerialLineOe),
		.misoOut(misoOut), .misoOe(misoOe), .rxData(rxData), .rxValid(rxValid), .rxMarker(rxMarker),
		.corrHit(corrHit), .corrMiss(corrMiss), .txData(txData), .txStrobe(txStrobe), .txMarker(txMarker),
		.modemMode(modemMode), .synthOn(synthOn), .radioTx(radioTx), .radioRx(radioRx),
		.txFifoLow(txFifoLow), .rxFifoHigh(rxFifoHigh), .packetDone(packetDone));
	// Modem byte capture
	always @(posedge clk) begin
		if (txStrobe === 1'b1) txSeen.push_back(txData);
		if (txMarker === 1'b1) markCount++;
		if (packetDone === 1'b1) doneCount++;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Reference checksum, bits in sending order
	function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] d[$]);
		logic [15:0] c;
		c = s;
		foreach (d[k]) for (int b = 7; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k][b]) ? 16'h8005 : 16'h0);
		return c;
	endfunction
	task automatic finalReport();
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic waitVal(ref logic s, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && s !== v; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == lim) begin
			failCount++;
			finalReport();
		end
	endtask
	task automatic wrq(input logic inc, input logic [5:0] a);
		m_u.xfer({1'b1, inc, a}, q);
	endtask
	task automatic rd(input logic [5:0] a, input int n, input logic inc);
		q = {};
		repeat (n) q.push_back(8'h00);
		m_u.xfer({1'b0, inc, a}, q);
	endtask
	task automatic newPay(input int n);
		pay = {};
		repeat (n) begin
			rng = xs(rng);
			pay.push_back(rng[7:0]);
		end
	endtask
	// One modem event: marker or data byte
	task automatic mdm(input logic mk, input logic [7:0] d);
		rxMarker = mk;
		rxValid = !mk;
		rxData = d;
		@(posedge clk);
		#1;
		rxMarker = 1'b0;
		rxValid = 1'b0;
		rxData = ~d;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// One correlation event: hit or miss
	task automatic cor(input logic h);
		{corrHit, corrMiss} = {h, !h};
		@(posedge clk);
		#1 {corrHit, corrMiss} = 2'h0;
		@(posedge clk) #1;
	endtask
	task automatic rxFrame(input logic [15:0] c);
		mdm(1'b1, 8'h00);
		mdm(1'b0, 8'(pay.size()));
		foreach (pay[k]) mdm(1'b0, pay[k]);
		mdm(1'b0, c[15:8]);
		mdm(1'b0, c[7:0]);
	endtask
	// Load nine bytes, start, compare the whole frame
	task automatic sendPkt(input logic [7:0] ctl);
		int n;
		newPay(9);
		n = 9;
		q = pay;
		wrq(1'b0, 6'h20);
		check("tx low flag", txFifoLow, 16'h0);
		txSeen = {};
		markCount = 0;
		q = '{ctl};
		wrq(1'b0, 6'h00);
		waitVal(packetDone, 1'b1, 4000);
		check("marker count", 16'(markCount), 16'h1);
		check("frame size", 16'(txSeen.size()), 16'(n + 3));
		check("length byte", txSeen[0], 16'(n));
		foreach (pay[k]) check("payload", txSeen[k + 1], pay[k]);
		check("checksum", {txSeen[n + 1], txSeen[n + 2]}, crc(seed, pay));
		check("tx low flag", txFifoLow, 16'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n = 1'b0;
		threePin = 1'b0;
		rxData = 8'h00;
		rxValid = 1'b0;
		rxMarker = 1'b0;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("idle outputs", {txStrobe, packetDone, radioTx, radioRx, modemMode}, 16'h0);
		rd(6'h00, 6, 1'b1);
		foreach (rv[k]) check("reset value", q[k], rv[k]);
		rng = xs(rng);
		seed = rng[15:0];
		mode = 3'(rng[23:16] % 6);
		q = '{8'(mode), 8'h05, seed[7:0], seed[15:8]};
		wrq(1'b1, 6'h01);
		q = '{8'h55, 8'h09};
		wrq(1'b0, 6'h02);
		rd(6'h01, 4, 1'b1);
		check("mode", q[0], 8'(mode));
		check("length", q[1], 8'h09);
		check("seed", {q[3], q[2]}, seed);
		check("mode pin", modemMode, mode);
		threePin = 1'b1;
		rd(6'h01, 1, 1'b0);
		check("shared line read", q[0], 8'(mode));
		threePin = 1'b0;
		rd(6'h10, 1, 1'b0);
		check("unmapped", q[0], 8'h00);
		q = '{8'h00};
		wrq(1'b0, 6'h01);
		sendPkt(8'h39);
		// Sequenced sends: answered, then left to time out
		for (int k = 0; k < 2; k++) begin
			sendPkt(8'h3D);
			waitVal(radioRx, 1'b1, 20);
			pay = {};
			if (k == 0) rxFrame(seed);
			waitVal(radioRx, 1'b0, 1000);
			rd(6'h06, 1, 1'b0);
			check("ack outcome", (k == 0) ? q[0][3] : q[0][4], 16'h1);
			q = '{8'hFF};
			wrq(1'b0, 6'h06);
		end
		// Receive: set seed, zero seed, corrupt checksum
		for (int c = 0; c < 3; c++) begin
			newPay(9);
			q = '{(c == 0) ? 8'h3E : 8'h3A};
			wrq(1'b0, 6'h00);
			txSeen = {};
			doneCount = 0;
			rxFrame((c == 2) ? ~crc(seed, pay) : crc((c == 1) ? 16'h0 : seed, pay));
			check("rx done", 16'(doneCount), 16'h1);
			check("rx high flag", rxFifoHigh, 16'h1);
			rd(6'h06, 1, 1'b0);
			check("checksum error", q[0][2], 16'(c == 2));
			if (c < 2) begin
				rd(6'h07, 1, 1'b0);
				check("rx length", q[0], 8'h09);
				rd(6'h21, 9, 1'b0);
				foreach (pay[k]) check("rx data", q[k], pay[k]);
			end
			check("ack frame", 16'(txSeen.size()), 16'(c == 0 ? 3 : 0));
			q = '{8'hFF};
			wrq(1'b0, 6'h06);
		end
		// Unframed receive ended by misses
		q = '{8'h42, 8'h05};
		wrq(1'b1, 6'h00);
		repeat (2) cor(1'b1);
		mdm(1'b0, 8'hA5);
		repeat (4) cor(1'b0);
		check("miss end", 16'(doneCount), 16'h2);
		finalReport();
	end
endmodule
`default_nettype wire
